// ===== design/inactivity_alarm_timer.sv
// inactivity alarm timer with wishbone register slave
`timescale 1ns/10ps
`default_nettype none
module inactivity_alarm_timer #(
    parameter logic [inactivity_alarm_pkg::TICK_W-1:0] MINUTE_DIV =
        inactivity_alarm_pkg::TICK_W'(inactivity_alarm_pkg::MINUTE_CYCLES)
) (
    // clock, reset, enable
    input  wire logic                                    clk_sys,
    input  wire logic                                    rstn,
    input  wire logic                                    clk_en,
    // wishbone slave
    input  wire logic [inactivity_alarm_pkg::ADDR_W-1:0] wb_adr_i,
    input  wire logic [31:0]                             wb_dat_i,
    input  wire logic [3:0]                              wb_sel_i,
    input  wire logic                                    wb_we_i,
    input  wire logic                                    wb_cyc_i,
    input  wire logic                                    wb_stb_i,
    output logic      [31:0]                             wb_dat_o,
    output logic                                         wb_ack_o,
    // activity sources
    input  wire logic                                    serial_port_one_irq,
    input  wire logic                                    serial_port_two_irq,
    // alarm outputs
    output logic                                         timeout_alarm_n,
    output logic      [inactivity_alarm_pkg::ROUTE_W-1:0] routed_irq,
    output logic                                         irq
);
    inactivity_alarm_pkg::wb_req_t req;
    inactivity_alarm_pkg::wb_rsp_t rsp;

    logic [7:0]                                timeout_period_reg;
    logic [7:0]                                trigger_mask_reg;
    logic [7:0]                                count_r;
    logic                                      active_r;
    logic                                      alarm_n_r;
    logic [inactivity_alarm_pkg::ROUTE_W-1:0]  route_r;
    logic                                      ack_r;
    logic [31:0]                               rdat_r;
    logic                                      acc;
    logic                                      wr;
    logic                                      wr_period;
    logic                                      wr_nonzero;
    logic                                      tick;
    logic                                      trigger;
    logic                                      trig_prev_r;
    logic                                      trig_level;
    logic                                      expire;
    logic [inactivity_alarm_pkg::IRQ_W-1:0]    irq_evt;
    logic [inactivity_alarm_pkg::IRQ_W-1:0]    irq_status;
    logic [inactivity_alarm_pkg::IRQ_W-1:0]    irq_mask;
    logic [inactivity_alarm_pkg::IDX_W-1:0]    idx;

    ////////////////////////////////////////////////////////////////////
    // bus decode

    // register index from a byte address
    function automatic logic [inactivity_alarm_pkg::IDX_W-1:0] reg_index(
        input logic [inactivity_alarm_pkg::ADDR_W-1:0] a
    );
        reg_index = a[inactivity_alarm_pkg::ADDR_W-1:inactivity_alarm_pkg::IDX_LSB];
    endfunction

    // classify an access; lane 0 must be selected for a write to count
    function automatic inactivity_alarm_pkg::acc_kind_t acc_kind(
        input logic [inactivity_alarm_pkg::IDX_W-1:0] i,
        input logic                                   w,
        input logic                                   lane0
    );
        if (!(w && lane0))
            acc_kind = inactivity_alarm_pkg::ACC_NONE;
        else if (i == {2'h0, inactivity_alarm_pkg::IDX_TIMEOUT_PERIOD})
            acc_kind = inactivity_alarm_pkg::ACC_TIMEOUT;
        else
            acc_kind = inactivity_alarm_pkg::ACC_OTHER;
    endfunction

    assign req.adr    = wb_adr_i;
    assign req.dat    = wb_dat_i;
    assign req.sel    = wb_sel_i;
    assign req.we     = wb_we_i;
    assign req.cyc    = wb_cyc_i;
    assign req.stb    = wb_stb_i;

    assign idx        = reg_index(req.adr);
    // one ack per request, ack drops at the next clk_en edge after it is given
    assign acc        = clk_en && req.cyc && req.stb && !ack_r;
    assign wr         = acc && req.we && req.sel[0];
    assign wr_period  = acc && acc_kind(idx, req.we, req.sel[0])
                        == inactivity_alarm_pkg::ACC_TIMEOUT;
    assign wr_nonzero = wr_period && req.dat[7:0] != inactivity_alarm_pkg::ZERO8;

    ////////////////////////////////////////////////////////////////////
    // minute tick and trigger detection

    minute_tick_gen #(
        .DIV     (MINUTE_DIV)
    ) u_tick (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .clk_en  (clk_en),
        .restart (wr_period || trigger),
        .tick    (tick)
    );

    // only unmasked sources contribute
    assign trig_level =
        (serial_port_two_irq && trigger_mask_reg[inactivity_alarm_pkg::MASK_PORT_TWO_BIT]) ||
        (serial_port_one_irq && trigger_mask_reg[inactivity_alarm_pkg::MASK_PORT_ONE_BIT]);

    always_ff @(posedge clk_sys or negedge rstn)
        if (!rstn)
            trig_prev_r <= 1'b0;
        else if (clk_en)
            trig_prev_r <= trig_level;

    // rising edge of the ORed unmasked irq level is one trigger event; no effect after expiry
    assign trigger = clk_en && active_r && trig_level && !trig_prev_r;

    ////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge clk_sys or negedge rstn)
        if (!rstn)
            timeout_period_reg <= inactivity_alarm_pkg::TIMEOUT_RST;
        else if (wr_period)
            timeout_period_reg <= req.dat[7:0];

    always_ff @(posedge clk_sys or negedge rstn)
        if (!rstn)
            trigger_mask_reg <= inactivity_alarm_pkg::MASK_RST;
        else if (wr && idx == {2'h0, inactivity_alarm_pkg::IDX_TRIGGER_MASK})
        begin
            trigger_mask_reg <= inactivity_alarm_pkg::ZERO8;
            trigger_mask_reg[inactivity_alarm_pkg::MASK_PORT_TWO_BIT] <=
                req.dat[inactivity_alarm_pkg::MASK_PORT_TWO_BIT];
            trigger_mask_reg[inactivity_alarm_pkg::MASK_PORT_ONE_BIT] <=
                req.dat[inactivity_alarm_pkg::MASK_PORT_ONE_BIT];
        end

    always_ff @(posedge clk_sys or negedge rstn)
        if (!rstn)
            route_r <= inactivity_alarm_pkg::ROUTE_RST;
        else if (wr && idx == inactivity_alarm_pkg::IDX_IRQ_ROUTE)
            route_r <= req.dat[inactivity_alarm_pkg::ROUTE_W-1:0];

    ////////////////////////////////////////////////////////////////////
    // countdown

    // writes win over a same-cycle tick or trigger
    always_ff @(posedge clk_sys or negedge rstn)
        if (!rstn)
        begin
            count_r  <= inactivity_alarm_pkg::ZERO8;
            active_r <= 1'b0;
        end
        else if (clk_en)
        begin
            if (wr_period)
            begin
                count_r  <= req.dat[7:0];
                active_r <= wr_nonzero;
            end
            else if (trigger)
                count_r <= timeout_period_reg;
            else if (active_r && tick)
            begin
                count_r <= count_r - 8'h01;
                if (count_r == 8'h01)
                    active_r <= 1'b0;
            end
        end

    assign expire = clk_en && !wr_period && !trigger && active_r && tick
                    && count_r == 8'h01;

    ////////////////////////////////////////////////////////////////////
    // alarm pin

    always_ff @(posedge clk_sys or negedge rstn)
        if (!rstn)
            alarm_n_r <= 1'b1;
        else if (clk_en)
        begin
            if (wr_period)
                alarm_n_r <= 1'b1;
            else if (expire)
                alarm_n_r <= 1'b0;
        end

    assign timeout_alarm_n = alarm_n_r;

    // route index 0 means not routed; index n drives routed_irq[n]
    genvar r;
    generate
        for (r = 0; r < inactivity_alarm_pkg::ROUTE_W; r++)
        begin : g_route
            assign routed_irq[r] = !alarm_n_r && route_r != inactivity_alarm_pkg::ROUTE_NONE
                                   && route_r == inactivity_alarm_pkg::ROUTE_W'(r);
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // interrupt status

    assign irq_evt[inactivity_alarm_pkg::IRQ_EXPIRE_BIT]  = expire;
    assign irq_evt[inactivity_alarm_pkg::IRQ_TRIGGER_BIT] = trigger;

    irq_status_block u_irq (
        .clk_sys  (clk_sys),
        .rstn     (rstn),
        .clk_en   (clk_en),
        .evt      (irq_evt),
        .st_wr    (wr && idx == inactivity_alarm_pkg::IDX_IRQ_STATUS),
        .msk_wr   (wr && idx == inactivity_alarm_pkg::IDX_IRQ_MASK),
        .wdat     (req.dat[inactivity_alarm_pkg::IRQ_W-1:0]),
        .status_r (irq_status),
        .mask_r   (irq_mask),
        .irq      (irq)
    );

    ////////////////////////////////////////////////////////////////////
    // read path

    always_ff @(posedge clk_sys or negedge rstn)
        if (!rstn)
            ack_r <= 1'b0;
        else if (clk_en)
            ack_r <= acc;

    always_ff @(posedge clk_sys or negedge rstn)
        if (!rstn)
            rdat_r <= '0;
        else if (acc && !req.we)
        begin
            rdat_r <= '0;
            case (idx)
                {2'h0, inactivity_alarm_pkg::IDX_TIMEOUT_PERIOD}:
                    rdat_r[7:0] <= timeout_period_reg;
                {2'h0, inactivity_alarm_pkg::IDX_TRIGGER_MASK}:
                    rdat_r[7:0] <= trigger_mask_reg;
                {2'h0, inactivity_alarm_pkg::IDX_ALARM_STATUS}:
                    rdat_r[inactivity_alarm_pkg::STATUS_ALARM_BIT] <= alarm_n_r;
                inactivity_alarm_pkg::IDX_IRQ_STATUS:
                    rdat_r[inactivity_alarm_pkg::IRQ_W-1:0] <= irq_status;
                inactivity_alarm_pkg::IDX_IRQ_MASK:
                    rdat_r[inactivity_alarm_pkg::IRQ_W-1:0] <= irq_mask;
                inactivity_alarm_pkg::IDX_IRQ_ROUTE:
                    rdat_r[inactivity_alarm_pkg::ROUTE_W-1:0] <= route_r;
                default:
                    rdat_r <= '0;
            endcase
        end

    assign rsp.ack  = ack_r;
    assign rsp.dat  = rdat_r;
    assign wb_ack_o = rsp.ack;
    assign wb_dat_o = rsp.dat;
endmodule
`default_nettype wire

// ===== design/inactivity_alarm_pkg.sv
// constants and types shared by the inactivity alarm timer
package inactivity_alarm_pkg;

    // register indices, byte address is four times the index
    localparam logic [1:0] IDX_TIMEOUT_PERIOD = 2'h0;
    localparam logic [1:0] IDX_TRIGGER_MASK   = 2'h1;
    localparam logic [1:0] IDX_ALARM_STATUS   = 2'h2;
    localparam logic [1:0] IDX_RESERVED       = 2'h3;
    // interrupt block registers
    localparam logic [3:0] IDX_IRQ_STATUS     = 4'h4;
    localparam logic [3:0] IDX_IRQ_MASK       = 4'h5;
    localparam logic [3:0] IDX_IRQ_ROUTE      = 4'h6;

    localparam int         ADDR_W             = 6;
    localparam int         IDX_LSB            = 2;
    localparam int         IDX_W              = 4;

    // reset values
    localparam logic [7:0] TIMEOUT_RST        = 8'h00;
    localparam logic [7:0] MASK_RST           = 8'h00;
    localparam logic [7:0] STATUS_IDLE        = 8'h01;
    localparam logic [7:0] ZERO8              = 8'h00;

    // field positions
    localparam int         MASK_PORT_TWO_BIT  = 3;
    localparam int         MASK_PORT_ONE_BIT  = 2;
    localparam int         STATUS_ALARM_BIT   = 0;
    localparam int         IRQ_EXPIRE_BIT     = 0;
    localparam int         IRQ_TRIGGER_BIT    = 1;
    localparam int         IRQ_W              = 2;
    localparam int         ROUTE_W            = 4;
    localparam logic [3:0] ROUTE_NONE         = 4'h0;
    localparam logic [3:0] ROUTE_RST          = 4'h0;

    // timing: one minute of clk_sys
    localparam longint     CLK_HZ             = 25000000;
    localparam longint     MINUTE_S           = 60;
    localparam longint     MINUTE_CYCLES      = CLK_HZ * MINUTE_S;
    localparam int         TICK_W             = 31;

    typedef struct packed {
        logic [ADDR_W-1:0] adr;
        logic [31:0]       dat;
        logic [3:0]        sel;
        logic              we;
        logic              cyc;
        logic              stb;
    } wb_req_t;

    typedef struct packed {
        logic [31:0]       dat;
        logic              ack;
    } wb_rsp_t;

    typedef enum logic [1:0] {
        ACC_NONE,
        ACC_TIMEOUT,
        ACC_OTHER
    } acc_kind_t;

endpackage

// ===== design/minute_tick_gen.sv
// free running divider making the one-minute tick
`timescale 1ns/10ps
`default_nettype none
module minute_tick_gen #(
    parameter logic [inactivity_alarm_pkg::TICK_W-1:0] DIV =
        inactivity_alarm_pkg::TICK_W'(inactivity_alarm_pkg::MINUTE_CYCLES)
) (
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic rstn,
    input  wire logic clk_en,
    // restart and tick
    input  wire logic restart,
    output logic      tick
);
    logic [inactivity_alarm_pkg::TICK_W-1:0] cnt_r;

    ////////////////////////////////////////////////////////////////////
    // restart aligns the first tick to a full minute after a load
    always_ff @(posedge clk_sys or negedge rstn)
        if (!rstn)
            cnt_r <= '0;
        else if (clk_en)
        begin
            if (restart || cnt_r == DIV - 1'b1)
                cnt_r <= '0;
            else
                cnt_r <= cnt_r + 1'b1;
        end

    assign tick = clk_en && !restart && (cnt_r == DIV - 1'b1);
endmodule
`default_nettype wire

// ===== design/irq_status_block.sv
// sticky event status, mask and level interrupt
`timescale 1ns/10ps
`default_nettype none
module irq_status_block (
    // clock and reset
    input  wire logic                                  clk_sys,
    input  wire logic                                  rstn,
    input  wire logic                                  clk_en,
    // events and software access
    input  wire logic [inactivity_alarm_pkg::IRQ_W-1:0] evt,
    input  wire logic                                  st_wr,
    input  wire logic                                  msk_wr,
    input  wire logic [inactivity_alarm_pkg::IRQ_W-1:0] wdat,
    // state
    output logic      [inactivity_alarm_pkg::IRQ_W-1:0] status_r,
    output logic      [inactivity_alarm_pkg::IRQ_W-1:0] mask_r,
    output logic                                       irq
);
    genvar g;
    generate
        for (g = 0; g < inactivity_alarm_pkg::IRQ_W; g++)
        begin : g_bit
            // set beats a write-one clear in the same cycle
            always_ff @(posedge clk_sys or negedge rstn)
                if (!rstn)
                    status_r[g] <= 1'b0;
                else if (clk_en)
                begin
                    if (evt[g])
                        status_r[g] <= 1'b1;
                    else if (st_wr && wdat[g])
                        status_r[g] <= 1'b0;
                end
        end
    endgenerate

    always_ff @(posedge clk_sys or negedge rstn)
        if (!rstn)
            mask_r <= '0;
        else if (clk_en && msk_wr)
            mask_r <= wdat;

    assign irq = |(status_r & mask_r);
endmodule
`default_nettype wire

// ===== test/serial_irq_model.sv
// far-side model: the two serial port interrupt lines
`timescale 1ns/10ps
`default_nettype none
module serial_irq_model #(
    parameter int HOLD = 4
) (
    // clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rstn,
    // bench requests, bit0 port one, bit1 port two
    input  wire logic [1:0] fire,
    // interrupt request lines
    output logic            serial_port_one_irq,
    output logic            serial_port_two_irq
);
    logic [7:0] hold_one_r;
    logic [7:0] hold_two_r;
    // a uart holds its request until serviced, modelled as a short level
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            hold_one_r <= 8'h00;
            hold_two_r <= 8'h00;
        end
        else
        begin
            hold_one_r <= fire[0] ? 8'(HOLD) : hold_one_r - 8'(hold_one_r != 8'h00);
            hold_two_r <= fire[1] ? 8'(HOLD) : hold_two_r - 8'(hold_two_r != 8'h00);
        end
    end
    assign serial_port_one_irq = hold_one_r != 8'h00;
    assign serial_port_two_irq = hold_two_r != 8'h00;
endmodule
`default_nettype wire

// ===== test/inactivity_alarm_monitor.sv
// port checker for the inactivity alarm timer
`timescale 1ns/10ps
`default_nettype none
module inactivity_alarm_monitor #(
    parameter logic [inactivity_alarm_pkg::TICK_W-1:0] MINUTE_DIV = 31'h14
) (
    // clock and reset
    input wire logic                                      clk_sys,
    input wire logic                                      rstn,
    input wire logic                                      clk_en,
    // wishbone
    input wire logic [inactivity_alarm_pkg::ADDR_W-1:0]   wb_adr_i,
    input wire logic [3:0]                                wb_sel_i,
    input wire logic                                      wb_we_i,
    input wire logic                                      wb_cyc_i,
    input wire logic                                      wb_stb_i,
    input wire logic [31:0]                               wb_dat_o,
    input wire logic                                      wb_ack_o,
    // alarm outputs
    input wire logic                                      timeout_alarm_n,
    input wire logic [inactivity_alarm_pkg::ROUTE_W-1:0]  routed_irq
);
    logic        take;
    logic        per_wr;
    logic [31:0] since_wr_r;
    assign take   = wb_cyc_i && wb_stb_i && clk_en && !wb_ack_o;
    assign per_wr = take && wb_we_i && wb_sel_i[0] && wb_adr_i[5:2] == 4'h0;
    // saturates so a long idle spell never wraps into a false early figure
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            since_wr_r <= 32'h0;
        else if (per_wr)
            since_wr_r <= 32'h0;
        else if (since_wr_r != 32'hffffffff)
            since_wr_r <= since_wr_r + 32'h1;
    end
    ////////////////////////////////////////
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);
    sequence s_take;
        take;
    endsequence
    sequence s_rd_status;
        take && !wb_we_i && wb_adr_i[5:2] == 4'h2;
    endsequence
    sequence s_per_wr;
        per_wr;
    endsequence
    a_ack_next_cycle: assert property (s_take |=> wb_ack_o)
        else $error("no ack one cycle after request");
    a_ack_single_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ack_needs_req: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
        else $error("ack without request");
    a_upper_bytes_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
        else $error("upper read bytes not zero");
    a_status_is_pin: assert property (s_rd_status |=> wb_dat_o == {31'h0, $past(timeout_alarm_n)})
        else $error("status does not show alarm level");
    a_write_releases: assert property (s_per_wr |=> timeout_alarm_n)
        else $error("period write left alarm low");
    a_alarm_holds_low: assert property (!timeout_alarm_n && !per_wr |=> !timeout_alarm_n)
        else $error("alarm released without period write");
    a_no_early_expiry: assert property ($fell(timeout_alarm_n) |-> since_wr_r >= 32'(MINUTE_DIV))
        else $error("alarm fell before one minute tick");
    a_route_follows: assert property (routed_irq != 4'h0 |-> !timeout_alarm_n && !routed_irq[0] && $onehot(routed_irq))
        else $error("routed irq without alarm");
endmodule
bind inactivity_alarm_timer inactivity_alarm_monitor #(.MINUTE_DIV(MINUTE_DIV)) mon (
    .clk_sys(clk_sys), .rstn(rstn), .clk_en(clk_en), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .timeout_alarm_n(timeout_alarm_n),
    .routed_irq(routed_irq));
`default_nettype wire

// ===== test/inactivity_alarm_timer_bench.sv
// self-checking bench for the inactivity alarm timer
`timescale 1ns/10ps
`default_nettype none
module inactivity_alarm_timer_bench;
    localparam int DIV = 20;
    logic                          clk_sys = 1'b0;
    logic                          rstn    = 1'b0;
    logic                          clk_en  = 1'b1;
    inactivity_alarm_pkg::wb_req_t req     = '0;
    logic [1:0]                    fire    = 2'h0;
    logic [31:0]                   wb_dat_o;
    logic                          wb_ack_o;
    logic                          port_one;
    logic                          port_two;
    logic                          alarm_n;
    logic [3:0]                    routed;
    logic                          irq;
    logic [31:0]                   q;
    int                            n;
    int                            fail_count = 0;
    int                            n_compared = 0;
    always #20 clk_sys = ~clk_sys;
    inactivity_alarm_timer #(.MINUTE_DIV(31'(DIV))) dut (
        .clk_sys(clk_sys), .rstn(rstn), .clk_en(clk_en), .wb_adr_i(req.adr),
        .wb_dat_i(req.dat), .wb_sel_i(req.sel), .wb_we_i(req.we), .wb_cyc_i(req.cyc),
        .wb_stb_i(req.stb), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .serial_port_one_irq(port_one), .serial_port_two_irq(port_two),
        .timeout_alarm_n(alarm_n), .routed_irq(routed), .irq(irq));
    serial_irq_model #(.HOLD(4)) far (
        .clk_sys(clk_sys), .rstn(rstn), .fire(fire),
        .serial_port_one_irq(port_one), .serial_port_two_irq(port_two));
    ////////////////////////////////////////
    task automatic stop_test();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            fail_count++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // classic cycle; read data taken at the ack edge only
    task automatic wb(input logic we, input logic [3:0] idx, input logic [7:0] d,
                      input logic [3:0] sel = 4'h1);
        int k;
        @(posedge clk_sys);
        req <= '{adr: {idx, 2'b00}, dat: {24'h0, d}, sel: sel, we: we, cyc: 1'b1, stb: 1'b1};
        k = 0;
        do
        begin
            @(posedge clk_sys);
            k++;
        end
        while (wb_ack_o !== 1'b1 && k < 64);
        q = wb_dat_o;
        req <= '0;
        if (k >= 64)
        begin
            fail_count++;
            stop_test();
        end
    endtask
    task automatic rd(input logic [3:0] idx, input logic [31:0] exp);
        wb(1'b0, idx, 8'h00);
        check(q, exp);
    endtask
    task automatic wait_fall();
        n = 0;
        do
        begin
            @(posedge clk_sys);
            n++;
        end
        while (alarm_n !== 1'b0 && n < 10 * DIV);
        if (alarm_n !== 1'b0)
        begin
            fail_count++;
            stop_test();
        end
    endtask
    ////////////////////////////////////////
    task automatic t_reset();
        check({31'h0, alarm_n}, 32'h1);
        check({31'h0, irq}, 32'h0);
        rd(4'h0, 32'h0);
        rd(4'h1, 32'h0);
        rd(4'h2, 32'h1);
        wb(1'b1, 4'h2, 8'h00);
        rd(4'h2, 32'h1);
        wb(1'b1, 4'h3, 8'h5a);
        rd(4'h3, 32'h0);
        wb(1'b1, 4'h1, 8'hff);
        rd(4'h1, 32'h0c);
        wb(1'b1, 4'h1, 8'h00, 4'h0);
        rd(4'h1, 32'h0c);
        $display("test reset done");
    endtask
    task automatic t_expiry();
        wb(1'b1, 4'h1, 8'h00);
        wb(1'b1, 4'h0, 8'h02);
        // a frozen enable must stretch the countdown by exactly the frozen edges
        clk_en <= 1'b0;
        repeat (DIV) @(posedge clk_sys);
        clk_en <= 1'b1;
        wait_fall();
        check(32'(n), 32'(2 * DIV));
        rd(4'h2, 32'h0);
        rd(4'h4, 32'h1);
        check({31'h0, irq}, 32'h0);
        wb(1'b1, 4'h5, 8'h01);
        check({31'h0, irq}, 32'h1);
        wb(1'b1, 4'h6, 8'h02);
        check({28'h0, routed}, 32'h4);
        wb(1'b1, 4'h4, 8'h01);
        check({31'h0, irq}, 32'h0);
        rd(4'h4, 32'h0);
        wb(1'b1, 4'h0, 8'h03);
        check({31'h0, alarm_n}, 32'h1);
        check({28'h0, routed}, 32'h0);
        rd(4'h2, 32'h1);
        $display("test expiry done");
    endtask
    // each port once unmasked (reload) and once masked (no effect)
    task automatic t_trigger();
        for (int p = 0; p < 2; p++)
        begin
            for (int hit = 0; hit < 2; hit++)
            begin
                wb(1'b1, 4'h1, p ? 8'h08 : 8'h04);
                wb(1'b1, 4'h0, 8'h02);
                repeat (DIV + 3) @(posedge clk_sys);
                fire <= 2'(1 << (hit ? p : 1 - p));
                @(posedge clk_sys);
                fire <= 2'h0;
                wait_fall();
                if (hit)
                    check(32'(n), 32'(2 * DIV + 2));
                else
                    check(32'(n), 32'(DIV - 4));
            end
        end
        rd(4'h4, 32'h3);
        $display("test trigger done");
    endtask
    task automatic t_reload_zero();
        wb(1'b1, 4'h0, 8'h05);
        rd(4'h0, 32'h5);
        repeat (DIV + 2) @(posedge clk_sys);
        wb(1'b1, 4'h0, 8'h01);
        wait_fall();
        check(32'(n), 32'(DIV));
        wb(1'b1, 4'h0, 8'hff);
        rd(4'h0, 32'hff);
        // short period so a zero write that failed to halt would expire here
        wb(1'b1, 4'h0, 8'h02);
        repeat (DIV) @(posedge clk_sys);
        wb(1'b1, 4'h0, 8'h00);
        repeat (8 * DIV) @(posedge clk_sys);
        check({31'h0, alarm_n}, 32'h1);
        check({28'h0, routed}, 32'h0);
        rd(4'h2, 32'h1);
        $display("test reload and zero done");
    endtask
    ////////////////////////////////////////
    initial
    begin
        repeat (8) @(posedge clk_sys);
        rstn <= 1'b1;
        @(posedge clk_sys);
        t_reset();
        t_expiry();
        t_trigger();
        t_reload_zero();
        stop_test();
    end
endmodule
`default_nettype wire
